//--- spc_port_ctrl.sv
// Per-port ingress/egress control registers with APB access and their decode
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "spc_cfg.svh"

module spc_port_ctrl #(
    parameter int NUM_PORTS = 3,
    parameter int VID_W     = 12
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Per-port packet context from the switch core
    input  wire logic [NUM_PORTS-1:0]          rx_is_ipv4,
    input  wire logic [NUM_PORTS-1:0]          rx_tagged,
    input  wire logic [NUM_PORTS-1:0]          dscp_hit,
    input  wire logic [NUM_PORTS*2-1:0]        dscp_prio,
    input  wire logic [NUM_PORTS-1:0]          dot1p_hit,
    input  wire logic [NUM_PORTS*2-1:0]        dot1p_prio,
    input  wire logic [NUM_PORTS*VID_W-1:0]    port_vid,
    input  wire logic [NUM_PORTS-1:0]          tx_arrived_tagged,
    input  wire logic [NUM_PORTS*2-1:0]        tx_ingress_port,
    // Per-port steering outputs
    output logic      [NUM_PORTS-1:0]          storm_protect_en,
    output spc_pkg::spc_prio_t [NUM_PORTS-1:0] rx_queue,
    output spc_pkg::spc_tag_act_t [NUM_PORTS-1:0] tx_tag_action,
    output logic      [NUM_PORTS*VID_W-1:0]    tx_insert_vid,
    output logic      [NUM_PORTS-1:0]          transmit_queue_split
);
    import spc_pkg::*;

    // Elaboration checks: the decoder serves three register slots at most
    if (NUM_PORTS < 1 || NUM_PORTS > 3) begin : g_bad_ports
        $error("NUM_PORTS must be 1 to 3");
    end
    if (VID_W < 1) begin : g_bad_vid
        $error("VID_W must be at least 1");
    end
    // Each register needs its own aligned word for the byte-lane logic to hold
    if ((`SPC_PORT1_OFFSET % 4) != 0 || (`SPC_PORT2_OFFSET % 4) != 0
        || (`SPC_PORT3_OFFSET % 4) != 0) begin : g_bad_align
        $error("register offsets must be word aligned");
    end

    // Field widths of the register layout
    localparam int REG_W  = 8;
    localparam int PRIO_W = 2;
    localparam int IDX_W  = 2;

    // One 8-bit control register per port, all with the same layout
    logic [REG_W-1:0] ctrl [NUM_PORTS];

    // Bus phases: taken in the first access cycle, completed in the second
    logic             take;
    logic             complete;
    logic             byte_en;
    logic             wr_commit;
    logic             rd_answer;

    assign take      = psel & penable & ~pready;
    assign complete  = psel & penable & pready;
    // Only byte lane 0 carries register bits; other lanes are ignored
    assign byte_en   = pstrb[0];
    // Writes land only at the completing edge, when pready is sampled high
    assign wr_commit = complete & pwrite & byte_en;
    assign rd_answer = take & ~pwrite;

    // Address decode
    logic             hit1;
    logic             hit2;
    logic             hit3;
    logic             mapped;
    logic [IDX_W-1:0] sel_idx;
    logic [REG_W-1:0] rd_byte;

    assign hit1   = (paddr == `SPC_PORT1_OFFSET);
    assign hit2   = (paddr == `SPC_PORT2_OFFSET) && (NUM_PORTS > 1);
    assign hit3   = (paddr == `SPC_PORT3_OFFSET) && (NUM_PORTS > 2);
    assign mapped = hit1 | hit2 | hit3;

    // First match wins; unmapped addresses fall to slot 0 and are masked
    always_comb begin
        sel_idx = 2'h0;
        if (hit1) begin
            sel_idx = 2'h0;
        end else if (hit2) begin
            sel_idx = 2'h1;
        end else if (hit3) begin
            sel_idx = 2'h2;
        end else begin
            sel_idx = 2'h0;
        end
    end

    // Unmapped reads return zero rather than a neighbour's contents
    always_comb begin
        rd_byte = 8'h00;
        if (mapped) begin
            rd_byte = ctrl[sel_idx];
        end else begin
            rd_byte = 8'h00;
        end
    end

    // Answer computed in the taken cycle
    logic             next_pready;
    logic             next_pslverr;
    logic [31:0]      next_prdata;

    assign next_pready  = take;
    assign next_pslverr = take & ~mapped;
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (rd_answer) begin
            next_prdata = {24'h00_0000, rd_byte};
        end else begin
            next_prdata = 32'h0000_0000;
        end
    end

    // Registered answer: pready, pslverr and prdata pulse for one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= next_pready;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= next_pslverr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            logic                wr_hit;
            logic [REG_W-1:0]    c;
            logic                storm_bit;
            logic                diffserv_bit;
            logic                dot1p_bit;
            logic [PRIO_W-1:0]   default_prio;
            logic                insert_bit;
            logic                remove_bit;
            logic                split_bit;

            logic                ds_on;
            logic                dp_on;
            logic [PRIO_W-1:0]   ds_p;
            logic [PRIO_W-1:0]   dp_p;
            logic [PRIO_W-1:0]   next_q;

            logic                ins;
            logic                rem;
            spc_tag_act_t        next_tag;

            logic [IDX_W-1:0]    src;
            logic [IDX_W-1:0]    src_ok;
            logic [VID_W-1:0]    next_vid;
            logic                next_storm;
            logic                next_split;

            assign wr_hit       = wr_commit & mapped & (sel_idx == IDX_W'(p));
            assign c            = ctrl[p];
            assign storm_bit    = c[`SPC_BIT_STORM];
            assign diffserv_bit = c[`SPC_BIT_DIFFSERV];
            assign dot1p_bit    = c[`SPC_BIT_DOT1P];
            assign default_prio = c[`SPC_PRIO_HI:`SPC_PRIO_LO];
            assign insert_bit   = c[`SPC_BIT_TAG_INSERT];
            assign remove_bit   = c[`SPC_BIT_TAG_REMOVE];
            assign split_bit    = c[`SPC_BIT_TXQ_SPLIT];

            assign ds_on = diffserv_bit & rx_is_ipv4[p] & dscp_hit[p];
            assign dp_on = dot1p_bit & dot1p_hit[p];

            // Masked classifier priorities
            always_comb begin
                ds_p = 2'h0;
                dp_p = 2'h0;
                if (ds_on) begin
                    ds_p = dscp_prio[PRIO_W*p +: PRIO_W];
                end
                if (dp_on) begin
                    dp_p = dot1p_prio[PRIO_W*p +: PRIO_W];
                end
            end

            // A classifier that is off or misses contributes nothing to the OR
            always_comb begin
                next_q = default_prio;
                if (ds_on | dp_on) begin
                    next_q = ds_p | dp_p;
                end else begin
                    next_q = default_prio;
                end
            end

            assign ins = insert_bit & ~tx_arrived_tagged[p];
            assign rem = remove_bit & tx_arrived_tagged[p];

            // With both tag bits set, untagged arrivals get a tag inserted and tagged arrivals have theirs removed
            always_comb begin
                next_tag = SPC_TAG_KEEP;
                if (ins) begin
                    next_tag = SPC_TAG_INSERT;
                end else if (rem) begin
                    next_tag = SPC_TAG_REMOVE;
                end else begin
                    next_tag = SPC_TAG_KEEP;
                end
            end

            // Out-of-range ingress indices fall back to port 0, never past the VID bus
            assign src = tx_ingress_port[IDX_W*p +: IDX_W];
            always_comb begin
                src_ok = 2'h0;
                if (int'(src) < NUM_PORTS) begin
                    src_ok = src;
                end else begin
                    src_ok = 2'h0;
                end
            end
            assign next_vid   = port_vid[VID_W*src_ok +: VID_W];
            assign next_storm = storm_bit;
            assign next_split = split_bit;

            // Reset leaves every feature off and the default queue at 0
            always_ff @(posedge clk) begin
                if (rst) begin
                    ctrl[p] <= `SPC_REG_RESET;
                end else if (wr_hit) begin
                    ctrl[p] <= pwdata[REG_W-1:0];
                end
            end

            always_ff @(posedge clk) begin
                if (rst) begin
                    storm_protect_en[p] <= 1'b0;
                end else begin
                    storm_protect_en[p] <= next_storm;
                end
            end

            always_ff @(posedge clk) begin
                if (rst) begin
                    rx_queue[p] <= 2'h0;
                end else begin
                    rx_queue[p] <= next_q;
                end
            end

            always_ff @(posedge clk) begin
                if (rst) begin
                    tx_tag_action[p] <= SPC_TAG_KEEP;
                end else begin
                    tx_tag_action[p] <= next_tag;
                end
            end

            // Global tag setup is software's duty; only the VID comes from here
            always_ff @(posedge clk) begin
                if (rst) begin
                    tx_insert_vid[VID_W*p +: VID_W] <= '0;
                end else begin
                    tx_insert_vid[VID_W*p +: VID_W] <= next_vid;
                end
            end

            always_ff @(posedge clk) begin
                if (rst) begin
                    transmit_queue_split[p] <= 1'b0;
                end else begin
                    transmit_queue_split[p] <= next_split;
                end
            end
        end
    endgenerate

endmodule : spc_port_ctrl
`default_nettype wire

//--- spc_cfg.svh
// Offsets, field positions and reset values of the per-port ingress/egress control registers
// Contract
// - Bit 7 set enables broadcast storm protection on received packets of that port.
// - Bit 6 set enables DiffServ priority classification of received IPv4 packets.
// - Bit 5 set enables 802.1p user priority classification of received packets.
// - Bits 4-3 give default queue 0..3 when classification is off or fails.
// - With both classifiers on, their ORed priority replaces the port default priority.
// - Tag insertion bit adds an 802.1p/q tag on egress to untagged arrivals.
// - With tag insertion on, packets already tagged on arrival get no extra tag.
// - An inserted tag carries the ingress port's default VLAN identifier.
// - Tag removal bit strips the 802.1p/q tag on egress from tagged arrivals.
// - With tag removal on, untagged arrivals pass through the port unmodified; the code does so only with tag insertion off, else it inserts a tag.
// - Bit 0 set splits the transmit queue into four; clear means one queue.
// - Each port has its own copy with identical layout at its own address.
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

`define SPC_PORT1_OFFSET     12'h010
`define SPC_PORT2_OFFSET     12'h020
`define SPC_PORT3_OFFSET     12'h030
`define SPC_REG_RESET        8'h00
`define SPC_BIT_STORM        7
`define SPC_BIT_DIFFSERV     6
`define SPC_BIT_DOT1P        5
`define SPC_PRIO_HI          4
`define SPC_PRIO_LO          3
`define SPC_BIT_TAG_INSERT   2
`define SPC_BIT_TAG_REMOVE   1
`define SPC_BIT_TXQ_SPLIT    0

`endif

//--- spc_pkg.sv
// Types shared by the per-port control register bank
package spc_pkg;
    typedef logic [1:0] spc_prio_t;
    typedef enum logic [1:0] {
        SPC_TAG_KEEP   = 2'h0,
        SPC_TAG_INSERT = 2'h1,
        SPC_TAG_REMOVE = 2'h2
    } spc_tag_act_t;
endpackage : spc_pkg

//--- spc_port_ctrl_properties.sv
// Bus timing and control-bit checks for the per-port control register bank
`timescale 1ns/10ps
`default_nettype none
`include "spc_cfg.svh"
module spc_port_ctrl_chk #(parameter int NUM_PORTS = 3) (
    input wire logic clk, rst, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0] pstrb,
    input wire logic [NUM_PORTS-1:0] storm_protect_en, transmit_queue_split
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire m = paddr == `SPC_PORT1_OFFSET || paddr == `SPC_PORT2_OFFSET
          || paddr == `SPC_PORT3_OFFSET;
    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_wr(a); pready && psel && pwrite && pstrb[0] && paddr == a; endsequence
    chk_one_wait: assert property (s_wait |=> pready) else $error("late ready");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
    chk_err_unmapped: assert property (pready |-> pslverr == !m) else $error("bad err");
    chk_rdata_high: assert property (pready |-> prdata[31:8] == 24'h0) else $error("hi");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("idle");
    // Output is registered behind the control register, hence two cycles
    chk_storm_bit: assert property (s_wr(`SPC_PORT1_OFFSET) |=> ##1
        storm_protect_en[0] == $past(pwdata[`SPC_BIT_STORM], 2)) else $error("storm");
    chk_split_bit: assert property (s_wr(`SPC_PORT2_OFFSET) |=> ##1
        transmit_queue_split[1] == $past(pwdata[`SPC_BIT_TXQ_SPLIT], 2)) else $error("split");
    chk_reset_clear: assert property (disable iff (1'b0) rst |=> storm_protect_en == '0
        && transmit_queue_split == '0) else $error("reset");
endmodule : spc_port_ctrl_chk
bind spc_port_ctrl spc_port_ctrl_chk #(.NUM_PORTS(NUM_PORTS)) i_spc_port_ctrl_chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pstrb(pstrb), .storm_protect_en(storm_protect_en),
    .transmit_queue_split(transmit_queue_split));
`default_nettype wire

//--- tb_spc_port_ctrl.sv
// Self-checking bench for the per-port control register bank
`timescale 1ns/10ps
`default_nettype none
`include "spc_cfg.svh"
module tb_spc_port_ctrl;
    import spc_pkg::*;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [11:0] paddr = '0, adr [3] = '{`SPC_PORT1_OFFSET, `SPC_PORT2_OFFSET, `SPC_PORT3_OFFSET};
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic [2:0] rx_is_ipv4 = '0, rx_tagged = '0, dscp_hit = 3'h1, dot1p_hit = 3'h1;
    logic [2:0] tx_arrived_tagged = '0, storm_protect_en, transmit_queue_split;
    logic [5:0] dscp_prio = 6'h1, dot1p_prio = 6'h2, tx_ingress_port = 6'h1;
    logic [35:0] port_vid = 36'h00a00b00c, tx_insert_vid;
    logic [8:0] cs [10] = '{9'h018, 9'h160, 9'h140, 9'h040, 9'h028, 9'h008,
                            9'h004, 9'h104, 9'h102, 9'h002};
    logic [1:0] ce [10] = '{3, 3, 1, 0, 2, 1, 1, 0, 2, 0};
    spc_prio_t [2:0] rx_queue;
    spc_tag_act_t [2:0] tx_tag_action;
    int num_errors = 0, tests_run = 0;
    always #25 clk = ~clk;
    spc_port_ctrl i_spc_port_ctrl (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_is_ipv4(rx_is_ipv4),
        .rx_tagged(rx_tagged), .dscp_hit(dscp_hit), .dscp_prio(dscp_prio),
        .dot1p_hit(dot1p_hit), .dot1p_prio(dot1p_prio), .port_vid(port_vid),
        .tx_arrived_tagged(tx_arrived_tagged), .tx_ingress_port(tx_ingress_port),
        .storm_protect_en(storm_protect_en), .rx_queue(rx_queue),
        .tx_tag_action(tx_tag_action), .tx_insert_vid(tx_insert_vid),
        .transmit_queue_split(transmit_queue_split));
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 3; i++) begin apb(0, adr[i], 0); chk("reset", 0, rd); end
        // Port 0 gets the storm bit, port 1 the four-queue split bit, port 2 stays clear
        for (int i = 0; i < 3; i++) apb(1, adr[i], 8'h80 >> (7 * i));
        for (int i = 0; i < 3; i++) begin apb(0, adr[i], 0); chk("copy", 8'h80 >> (7 * i), rd); end
        chk("storm", 3'h1, storm_protect_en);
        chk("split", 3'h2, transmit_queue_split);
        pstrb <= 4'h0;
        apb(1, adr[0], 8'hff);
        pstrb <= 4'hf;
        apb(1, 12'h014, 8'hff); chk("wr err", 1, er);
        apb(0, 12'h014, 0); chk("rd err", 1, er); chk("rd unmapped", 0, rd);
        apb(0, adr[0], 0); chk("masked wr", 8'h80, rd);
        // Cases 0-5 steer the queue choice, 6-9 the egress tag action
        for (int i = 0; i < 10; i++) begin
            rx_is_ipv4 <= {2'h0, cs[i][8]};
            tx_arrived_tagged <= {2'h0, cs[i][8]};
            apb(1, adr[0], cs[i][7:0]);
            repeat (2) @(posedge clk);
            if (i < 6) chk("queue", ce[i], rx_queue[0]);
            else chk("tag", ce[i], tx_tag_action[0]);
            // Global tag setup is taken as done by software before insertion is used
            if (i == 6) chk("vid", 12'h00b, tx_insert_vid[11:0]);
        end
        close_out();
    end
    initial begin
        #50us;
        num_errors++;
        close_out();
    end
endmodule : tb_spc_port_ctrl
`default_nettype wire
